// File: fst_deglitch.sv
// Persistence filter: trips after the raw fault stays high for a set count
`timescale 1ns/1ps
module fst_deglitch
	import fst_pkg::*;
(
	input  wire logic              i_core_clk,
	input  wire logic              i_resetn,
	input  wire logic              i_ce,
	input  wire logic              i_raw,
	input  wire logic [FILT_W-1:0] i_limit,
	output logic                   o_trip
);
	logic [FILT_W-1:0] cnt_reg;
	logic [FILT_W-1:0] cnt_next;

	assign cnt_next = cnt_reg + {{(FILT_W-1){1'b0}}, 1'b1};

	// Any low sample restarts the count
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_reg <= '0;
			o_trip  <= 1'b0;
		end else if (i_ce) begin
			if (!i_raw) begin
				cnt_reg <= '0;
				o_trip  <= 1'b0;
			end else if (!o_trip) begin
				cnt_reg <= cnt_next;
				o_trip  <= (cnt_next >= i_limit);
			end
		end
	end

	a_trip_needs_raw: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		o_trip |-> $past(i_raw) || !$past(i_ce)) else $error("filter tripped without raw fault");
endmodule : fst_deglitch

// File: fst_pin_model.sv
// Host-side model of the two sensed safety pins
`timescale 1ns/1ps
module fst_pin_model (
	input  wire logic i_reset_pin_n,
	input  wire logic i_safety_pin_n,
	output logic      o_reset_sense,
	output logic      o_safety_sense
);
	// Both pins are actively driven, so the sense follows the driven level
	assign o_reset_sense  = i_reset_pin_n;
	assign o_safety_sense = i_safety_pin_n;
endmodule : fst_pin_model

// File: fst_pkg.sv
// Constants, types and register map of the fault response and self-test block
package fst_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int          CLK_MHZ    = 125;
	localparam int          CLK_PER_MS = CLK_MHZ * 1000;
	localparam int unsigned THERM_US [4] = '{50, 100, 1000, 2500};
	localparam int unsigned ARCH_US  [4] = '{10, 25, 50, 100};
	localparam int unsigned SST_MS   [4] = '{64, 128, 256, 512};
	localparam int          FILT_W     = 19;
	localparam int          SST_W      = 26;
	localparam logic [3:0]  PIN_SETTLE = 4'h8;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int NREC   = 19;
	localparam int NGRP   = 13;
	localparam int NPIN   = 8;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_STAT0 = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_STAT1 = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_IMASK = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_SMASK = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_CFG0  = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_CFG1  = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_OVR   = 4'h6;
	localparam logic [ADDR_W-1:0] ADDR_CTRL  = 4'h7;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG0_THERM_SEL  = 0;
	localparam int CFG0_THERM_RESP = 2;
	localparam int CFG0_ARCH_SEL   = 4;
	localparam int CFG0_ARCH_RESP  = 6;
	localparam int CFG0_CHK_RESP   = 8;
	localparam int CFG0_TOACC_RESP = 10;
	localparam int CFG0_ACC_RESP   = 12;
	localparam int CFG1_CD_ACT     = 0;
	localparam int CFG1_PD_ACT     = 1;
	localparam int CFG1_WU_ACT     = 2;
	localparam int CTRL_EXIT       = 0;

	// Record bit positions
	localparam int REC_THERM   = 0;
	localparam int REC_SPI_TXN = 1;
	localparam int REC_SPI_MM  = 2;
	localparam int REC_ARCH    = 3;
	localparam int REC_CFG     = 7;
	localparam int REC_WDT     = 8;
	localparam int REC_TOACC   = 8;
	localparam int REC_ACC     = 10;
	localparam int REC_SST     = 14;
	localparam int REC_CD      = 15;
	localparam int REC_OVF     = 16;
	localparam int REC_PD      = 17;
	localparam int REC_WU      = 18;

	// Mask groups that may pull the safety output
	localparam logic [NGRP-1:0] SAFE_GRP = 13'h00F5;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [NGRP-1:0] MASK_RST = 13'h0000;
	localparam logic [13:0]     CFG0_RST = 14'h0000;
	localparam logic [2:0]      CFG1_RST = 3'h0;
	localparam logic [15:0]     OVR_RST  = 16'h0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OVR_PASS = 2'b00,
		OVR_HOLD = 2'b01,
		OVR_HIGH = 2'b10,
		OVR_LOW  = 2'b11
	} fst_ovr_t;

	typedef enum logic [2:0] {
		ST_LOGIC_SELF_TEST  = 3'b000,
		ST_ANALOG_SELF_TEST  = 3'b001,
		ST_PINCHK = 3'b010,
		ST_INIT   = 3'b011,
		ST_SST    = 3'b100,
		ST_ACTIVE = 3'b101,
		ST_FAIL   = 3'b110
	} fst_state_t;
endpackage : fst_pkg

// File: fst_top.sv
// Fault recording, response and startup/system self-test sequencing
// Summary of operation
// - Thermal fault filtered 50/100/1000/2500 us, recorded, response case 0 to 3.
// - Two serial faults recorded separately, one shared interrupt mask, no response.
// - One filter time 10/25/50/100 us for four ground/reference faults, own records.
// - Ground/reference faults share one response case, interrupt mask, safety mask.
// - Configuration recheck mismatch sets its record and applies its response case.
// - Watchdog accumulator faults get responses; other watchdog faults only recorded.
// - Self-test timer expiry records fault, applies response, raises maskable interrupt.
// - Countdown expiry and wakeup events record alarm, optionally exit low power.
// - Power-down point records alarm and optionally enters low power.
// - Counter-limit overflow records alarm only, maskable from interrupt.
// - Startup self-tests finish before converter and regulators are enabled.
// - Logic self-test covers the safety monitoring logic.
// - Startup checks reset and safety output pins for stuck-at faults.
// - After reset output goes high in init, enter system self-test, monitors live.
// - Safety output asserts only in the pin-check high phase and after system self-test completes.
// - Each checked pin has override: pass-through, hold, force high, force low.
// - Hold latches the pin value and presents it until the override changes.
// - Overrides cover error, monitor, wakes, standby, power, interrupt, watchdog pins.
// - Self-test timer starts on reset output rising edge, duration from option.
// - Host writes exit bit before expiry; timer stops and state goes active.
// - Missing exit write before timeout raises self-test fault, configured handling.
`timescale 1ns/1ps
module fst_top
	import fst_pkg::*;
#(
	parameter int unsigned P_THERM_CYC [4] = '{THERM_US[0] * CLK_MHZ, THERM_US[1] * CLK_MHZ,
	                                           THERM_US[2] * CLK_MHZ, THERM_US[3] * CLK_MHZ},
	parameter int unsigned P_ARCH_CYC  [4] = '{ARCH_US[0] * CLK_MHZ, ARCH_US[1] * CLK_MHZ,
	                                           ARCH_US[2] * CLK_MHZ, ARCH_US[3] * CLK_MHZ},
	parameter int unsigned P_SST_CYC   [4] = '{SST_MS[0] * CLK_PER_MS, SST_MS[1] * CLK_PER_MS,
	                                           SST_MS[2] * CLK_PER_MS, SST_MS[3] * CLK_PER_MS}
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_resetn,
	input  wire logic              i_ce,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [DATA_W-1:0] o_rdata,
	input  wire logic              i_thermal_raw,
	input  wire logic              i_spi_txn_fault,
	input  wire logic              i_spi_mismatch,
	input  wire logic [3:0]        i_arch_raw,
	input  wire logic              i_config_mismatch,
	input  wire logic [5:0]        i_wdt_fault,
	input  wire logic              i_eot_countdown,
	input  wire logic              i_eot_overflow,
	input  wire logic              i_eot_powerdown,
	input  wire logic              i_eot_wakeup,
	input  wire logic              i_logic_self_test_done,
	input  wire logic              i_logic_self_test_pass,
	input  wire logic              i_analog_self_test_done,
	input  wire logic              i_analog_self_test_pass,
	input  wire logic              i_mcu_reset_sense,
	input  wire logic              i_safety_sense,
	input  wire logic [1:0]        i_self_test_timeout_sel,
	input  wire logic [1:0]        i_sst_response,
	input  wire logic [NPIN-1:0]   i_pin_raw,
	output logic      [NPIN-1:0]   o_pin_value,
	output logic                   o_mcu_reset_out_n,
	output logic                   o_safety_shutdown_out_n,
	output logic                   o_host_interrupt_n,
	output logic                   o_converter_en,
	output logic                   o_regulator_en,
	output logic                   o_resp_valid,
	output logic      [1:0]        o_resp_case,
	output logic                   o_lowpower_enter,
	output logic                   o_lowpower_exit
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [NGRP-1:0] grp_of(input logic [NREC-1:0] r);
		grp_of = {r[REC_WU], r[REC_PD], r[REC_OVF], r[REC_CD], r[REC_SST],
		          |r[13:11], r[REC_ACC], r[REC_TOACC+1], r[REC_TOACC], r[REC_CFG],
		          |r[REC_ARCH+3:REC_ARCH], |r[REC_SPI_MM:REC_SPI_TXN], r[REC_THERM]};
	endfunction : grp_of

	// Higher case taken as the more severe reaction
	function automatic logic [1:0] max_case(input logic [1:0] a, input logic [1:0] b);
		max_case = (a > b) ? a : b;
	endfunction : max_case

	function automatic logic ovr_apply(input logic [1:0] m, input logic raw, input logic held);
		case (m)
			OVR_PASS: ovr_apply = raw;
			OVR_HOLD: ovr_apply = held;
			OVR_HIGH: ovr_apply = 1'b1;
			OVR_LOW:  ovr_apply = 1'b0;
			default:  ovr_apply = raw;
		endcase
	endfunction : ovr_apply

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	fst_state_t        state_reg;
	logic [NREC-1:0]   rec_reg;
	logic [NREC-1:0]   rec_next;
	logic [NREC-1:0]   rec_set;
	logic [NREC-1:0]   rec_clr;
	logic [NREC-1:0]   prev_reg;
	logic [NREC-1:0]   rise;
	logic [NGRP-1:0]   imask_reg;
	logic [NGRP-1:0]   smask_reg;
	logic [13:0]       cfg0_reg;
	logic [2:0]        cfg1_reg;
	logic [15:0]       ovr_reg;
	logic [NPIN-1:0]   hold_reg;
	logic [SST_W-1:0]  sst_cnt_reg;
	logic              sst_run_reg;
	logic              sst_to;
	logic              rst_prev_reg;
	logic              rst_rise;
	logic              pin_phase_reg;
	logic [3:0]        pin_cnt_reg;
	logic              exit_wr;
	logic              therm_trip;
	logic [3:0]        arch_trip;
	logic [FILT_W-1:0] therm_lim;
	logic [FILT_W-1:0] arch_lim;
	logic [SST_W-1:0]  sst_lim;
	logic              resp_any;
	logic [1:0]        resp_sel;

	// ----------------------------------------------------------------
	// Deglitch filters
	// ----------------------------------------------------------------
	assign therm_lim = FILT_W'(P_THERM_CYC[cfg0_reg[CFG0_THERM_SEL +: 2]]);
	assign arch_lim  = FILT_W'(P_ARCH_CYC[cfg0_reg[CFG0_ARCH_SEL +: 2]]);

	fst_deglitch u_therm_filt (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_ce       (i_ce),
		.i_raw      (i_thermal_raw),
		.i_limit    (therm_lim),
		.o_trip     (therm_trip)
	);

	// One shared time, separate persistence per fault
	for (genvar g = 0; g < 4; g++) begin : g_arch
		fst_deglitch u_arch_filt (
			.i_core_clk (i_core_clk),
			.i_resetn   (i_resetn),
			.i_ce       (i_ce),
			.i_raw      (i_arch_raw[g]),
			.i_limit    (arch_lim),
			.o_trip     (arch_trip[g])
		);
	end

	// ----------------------------------------------------------------
	// Fault recording
	// ----------------------------------------------------------------
	assign rec_set = {i_eot_wakeup, i_eot_powerdown, i_eot_overflow, i_eot_countdown, sst_to,
	                  i_wdt_fault, i_config_mismatch, arch_trip, i_spi_mismatch,
	                  i_spi_txn_fault, therm_trip};
	assign rise    = rec_set & ~prev_reg;
	assign rec_clr = (i_wr && i_addr == ADDR_STAT0) ? {4'h0, i_wdata[14:0]} :
	                 (i_wr && i_addr == ADDR_STAT1) ? {i_wdata[3:0], 15'h0000} : '0;
	// Set beats clear; masks play no part in recording
	assign rec_next = (rec_reg & ~rec_clr) | rec_set;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rec_reg  <= '0;
			prev_reg <= '0;
		end else if (i_ce) begin
			rec_reg  <= rec_next;
			prev_reg <= rec_set;
		end
	end

	// ----------------------------------------------------------------
	// Response selection
	// ----------------------------------------------------------------
	always_comb begin
		resp_any = 1'b0;
		resp_sel = 2'b00;
		if (rise[REC_THERM]) begin
			resp_any = 1'b1;
			resp_sel = max_case(resp_sel, cfg0_reg[CFG0_THERM_RESP +: 2]);
		end
		if (|rise[REC_ARCH+3:REC_ARCH]) begin
			resp_any = 1'b1;
			resp_sel = max_case(resp_sel, cfg0_reg[CFG0_ARCH_RESP +: 2]);
		end
		if (rise[REC_CFG]) begin
			resp_any = 1'b1;
			resp_sel = max_case(resp_sel, cfg0_reg[CFG0_CHK_RESP +: 2]);
		end
		if (rise[REC_TOACC]) begin
			resp_any = 1'b1;
			resp_sel = max_case(resp_sel, cfg0_reg[CFG0_TOACC_RESP +: 2]);
		end
		if (rise[REC_ACC]) begin
			resp_any = 1'b1;
			resp_sel = max_case(resp_sel, cfg0_reg[CFG0_ACC_RESP +: 2]);
		end
		if (rise[REC_SST]) begin
			resp_any = 1'b1;
			resp_sel = max_case(resp_sel, i_sst_response);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_resp_valid     <= 1'b0;
			o_resp_case      <= 2'b00;
			o_lowpower_enter <= 1'b0;
			o_lowpower_exit  <= 1'b0;
		end else if (i_ce) begin
			o_resp_valid     <= resp_any;
			o_resp_case      <= resp_sel;
			o_lowpower_enter <= rise[REC_PD] && cfg1_reg[CFG1_PD_ACT];
			o_lowpower_exit  <= (rise[REC_CD] && cfg1_reg[CFG1_CD_ACT]) ||
			                    (rise[REC_WU] && cfg1_reg[CFG1_WU_ACT]);
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	assign exit_wr = i_wr && i_addr == ADDR_CTRL && i_wdata[CTRL_EXIT];

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			imask_reg <= MASK_RST;
			smask_reg <= MASK_RST;
			cfg0_reg  <= CFG0_RST;
			cfg1_reg  <= CFG1_RST;
			ovr_reg   <= OVR_RST;
		end else if (i_ce && i_wr) begin
			case (i_addr)
				ADDR_IMASK: imask_reg <= i_wdata[NGRP-1:0];
				ADDR_SMASK: smask_reg <= i_wdata[NGRP-1:0] & SAFE_GRP;
				ADDR_CFG0:  cfg0_reg  <= i_wdata[13:0];
				ADDR_CFG1:  cfg1_reg  <= i_wdata[2:0];
				ADDR_OVR:   ovr_reg   <= i_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= '0;
		end else if (i_ce) begin
			if (i_rd) begin
				case (i_addr)
					ADDR_STAT0: o_rdata <= {1'b0, rec_reg[14:0]};
					ADDR_STAT1: o_rdata <= {12'h000, rec_reg[NREC-1:15]};
					ADDR_IMASK: o_rdata <= {3'h0, imask_reg};
					ADDR_SMASK: o_rdata <= {3'h0, smask_reg};
					ADDR_CFG0:  o_rdata <= {2'h0, cfg0_reg};
					ADDR_CFG1:  o_rdata <= {13'h0000, cfg1_reg};
					ADDR_OVR:   o_rdata <= ovr_reg;
					ADDR_CTRL:  o_rdata <= {12'h000, sst_run_reg, state_reg};
					default:    o_rdata <= '0;
				endcase
			end else begin
				o_rdata <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin overrides
	// ----------------------------------------------------------------
	// Pins: error, monitor, wake a, wake b, standby, power, interrupt, watchdog
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			hold_reg    <= '0;
			o_pin_value <= '0;
		end else if (i_ce) begin
			for (int p = 0; p < NPIN; p++) begin
				if (ovr_reg[2*p +: 2] != OVR_HOLD) begin
					hold_reg[p] <= i_pin_raw[p];
				end
				o_pin_value[p] <= ovr_apply(ovr_reg[2*p +: 2], i_pin_raw[p], hold_reg[p]);
			end
		end
	end

	// ----------------------------------------------------------------
	// System self-test timer
	// ----------------------------------------------------------------
	assign rst_rise = o_mcu_reset_out_n && !rst_prev_reg;
	assign sst_lim  = SST_W'(P_SST_CYC[i_self_test_timeout_sel]);
	assign sst_to   = sst_run_reg && !exit_wr && (sst_cnt_reg == sst_lim - 1'b1);

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_prev_reg <= 1'b0;
			sst_run_reg  <= 1'b0;
			sst_cnt_reg  <= '0;
		end else if (i_ce) begin
			rst_prev_reg <= o_mcu_reset_out_n;
			if (rst_rise) begin
				sst_run_reg <= 1'b1;
				sst_cnt_reg <= '0;
			end else if (sst_run_reg) begin
				if (exit_wr || sst_to) begin
					sst_run_reg <= 1'b0;
				end else begin
					sst_cnt_reg <= sst_cnt_reg + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Startup sequence
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg     <= ST_LOGIC_SELF_TEST;
			pin_phase_reg <= 1'b0;
			pin_cnt_reg   <= 4'h0;
		end else if (i_ce) begin
			case (state_reg)
				ST_LOGIC_SELF_TEST: begin
					if (i_logic_self_test_done) begin
						state_reg <= i_logic_self_test_pass ? ST_ANALOG_SELF_TEST : ST_FAIL;
					end
				end
				ST_ANALOG_SELF_TEST: begin
					if (i_analog_self_test_done) begin
						state_reg <= i_analog_self_test_pass ? ST_PINCHK : ST_FAIL;
					end
				end
				ST_PINCHK: begin
					// Brief high phase also pulses the reset pin; unavoidable for stuck-low
					if (pin_cnt_reg != PIN_SETTLE) begin
						pin_cnt_reg <= pin_cnt_reg + 4'h1;
					end else if (i_mcu_reset_sense != pin_phase_reg ||
					             i_safety_sense != pin_phase_reg) begin
						state_reg <= ST_FAIL;
					end else begin
						pin_cnt_reg   <= 4'h0;
						pin_phase_reg <= !pin_phase_reg;
						if (pin_phase_reg) begin
							state_reg <= ST_INIT;
						end
					end
				end
				ST_INIT: begin
					if (o_mcu_reset_out_n && rst_prev_reg) begin
						state_reg <= ST_SST;
					end
				end
				ST_SST: begin
					if (exit_wr) begin
						state_reg <= ST_ACTIVE;
					end
				end
				ST_ACTIVE: ;
				ST_FAIL: ;
				default: state_reg <= ST_FAIL;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Output pins
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_mcu_reset_out_n       <= 1'b0;
			o_safety_shutdown_out_n <= 1'b0;
			o_host_interrupt_n      <= 1'b1;
			o_converter_en          <= 1'b0;
			o_regulator_en          <= 1'b0;
		end else if (i_ce) begin
			// Reset drops for the first init cycle after pin check, so the timer starts on the rise in init
			o_mcu_reset_out_n <= (state_reg == ST_PINCHK && pin_phase_reg &&
			                      pin_cnt_reg != PIN_SETTLE) ||
			                     state_reg == ST_INIT || state_reg == ST_SST ||
			                     state_reg == ST_ACTIVE;
			o_safety_shutdown_out_n <= (state_reg == ST_PINCHK && pin_phase_reg) ||
			                           (state_reg == ST_ACTIVE &&
			                            !(|(grp_of(rec_reg) & SAFE_GRP & ~smask_reg)));
			o_host_interrupt_n <= !(|(grp_of(rec_reg) & ~imask_reg));
			o_converter_en <= state_reg == ST_INIT || state_reg == ST_SST ||
			                  state_reg == ST_ACTIVE;
			o_regulator_en <= o_converter_en && state_reg != ST_FAIL;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	a_safe_after_sst: assert property (o_safety_shutdown_out_n |->
		$past(state_reg) == ST_ACTIVE || $past(state_reg) == ST_PINCHK)
		else $error("safety output before self-test done");
	a_exit_to_active: assert property (i_ce && exit_wr && state_reg == ST_SST |=>
		state_reg == ST_ACTIVE && !sst_run_reg) else $error("exit write not honoured");
	a_timer_start: assert property (i_ce && rst_rise |=>
		sst_run_reg && sst_cnt_reg == '0) else $error("timer not started on reset rise");
	a_timeout_rec: assert property (i_ce && sst_to |=>
		rec_reg[REC_SST] && o_resp_valid && o_resp_case >= $past(i_sst_response))
		else $error("timeout not recorded");
	a_rec_no_mask: assert property (i_ce && |rec_set |=>
		(rec_reg & $past(rec_set)) == $past(rec_set)) else $error("event record lost");
	a_int_follows: assert property (o_host_interrupt_n ==
		!(|(grp_of($past(rec_reg)) & ~$past(imask_reg))) || !$past(i_ce))
		else $error("interrupt output mismatch");
	a_enable_late: assert property (o_converter_en |->
		$past(state_reg) inside {ST_INIT, ST_SST, ST_ACTIVE}) else $error("early enable");
	a_hold_stable: assert property (i_ce && ovr_reg[1:0] == OVR_HOLD |=>
		hold_reg[0] == $past(hold_reg[0])) else $error("held value moved");
	a_force_high: assert property (i_ce && ovr_reg[1:0] == OVR_HIGH |=>
		o_pin_value[0]) else $error("forced high not applied");
	a_cd_exit: assert property (i_ce && rise[REC_CD] && cfg1_reg[CFG1_CD_ACT] |=>
		o_lowpower_exit) else $error("countdown exit missing");
	a_therm_case: assert property (i_ce && rise[REC_THERM] |=> o_resp_valid &&
		o_resp_case >= $past(cfg0_reg[CFG0_THERM_RESP +: 2])) else $error("thermal case lost");

	c_reach_active: cover property (state_reg == ST_SST ##1 state_reg == ST_ACTIVE);
	c_sst_timeout: cover property (sst_to);
	c_therm_resp: cover property (rise[REC_THERM] ##1 o_resp_valid);
	c_pin_fail: cover property (state_reg == ST_PINCHK ##1 state_reg == ST_FAIL);
endmodule : fst_top

// File: fst_top_test.sv
// Self-checking bench for the fault response and self-test block
`timescale 1ns/1ps
module fst_top_test;
	import fst_pkg::*;
	logic        clk = 0, rstn = 0, wr = 0, rd = 0, therm = 0, rs, ss, rn, sn, intn;
	logic [3:0]  addr = 0;
	logic [15:0] wd = 0, rdat;
	logic [16:0] flt = 0;
	logic [3:0]  bist = 4'hF;
	logic [7:0]  pin = 0, pv;
	logic        rv, lpe, lpx, cen, ren;
	logic [1:0]  rc;
	int          errors = 0, total_checks = 0, cyc = 0;
	fst_top #(.P_THERM_CYC('{4, 6, 8, 10}), .P_ARCH_CYC('{4, 6, 8, 10}),
		.P_SST_CYC('{200, 300, 400, 500})) i_dut (.i_core_clk(clk), .i_resetn(rstn),
		.i_ce(1'b1), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
		.i_thermal_raw(therm), .i_spi_txn_fault(flt[0]), .i_spi_mismatch(flt[1]),
		.i_arch_raw(flt[5:2]), .i_config_mismatch(flt[6]), .i_wdt_fault(flt[12:7]),
		.i_eot_countdown(flt[13]), .i_eot_overflow(flt[14]), .i_eot_powerdown(flt[15]),
		.i_eot_wakeup(flt[16]), .i_logic_self_test_done(bist[0]), .i_logic_self_test_pass(bist[1]),
		.i_analog_self_test_done(bist[2]), .i_analog_self_test_pass(bist[3]), .i_mcu_reset_sense(rs),
		.i_safety_sense(ss), .i_self_test_timeout_sel(2'h0), .i_sst_response(2'h3),
		.i_pin_raw(pin), .o_pin_value(pv), .o_mcu_reset_out_n(rn),
		.o_safety_shutdown_out_n(sn), .o_host_interrupt_n(intn), .o_converter_en(cen),
		.o_regulator_en(ren), .o_resp_valid(rv), .o_resp_case(rc), .o_lowpower_enter(lpe),
		.o_lowpower_exit(lpx));
	fst_pin_model i_pins (.i_reset_pin_n(rn), .i_safety_pin_n(sn), .o_reset_sense(rs),
		.o_safety_sense(ss));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
		rd <= 0;
		#1;
	endtask : bus
	task automatic hi_for(input int n);
		@(posedge clk);
		therm <= 1;
		repeat (n) @(posedge clk);
		therm <= 0;
	endtask : hi_for
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			errors++;
			finish_test();
		end
	end
	task automatic wait_resp(input int n);
		for (int i = 0; i < n && rv !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
	endtask : wait_resp
	task automatic reset_dut;
		rstn <= 0;
		repeat (5) @(posedge clk);
		rstn <= 1;
		// Startup self-tests, then wait for system self-test state
		for (int i = 0; i < 100 && rdat[2:0] !== ST_SST; i++) bus(0, ADDR_CTRL, 0);
		chk("ctrl state", 16'h000C, rdat);
		chk("reset pin", 16'h0001, rn);
		chk("safety pin", 16'h0000, sn);
		chk("enables", 16'h0003, {cen, ren});
	endtask : reset_dut
	task automatic serial_masked;
		// Masked serial faults still record, no interrupt
		bus(1, ADDR_IMASK, 16'h0002);
		flt[1:0] <= 2'b11;
		@(posedge clk);
		flt[1:0] <= 2'b00;
		bus(0, ADDR_STAT0, 0);
		chk("stat0 spi", 16'h0006, rdat);
		chk("int pin", 16'h0001, intn);
		bus(1, ADDR_STAT0, 16'h0006);
		bus(1, ADDR_CTRL, 16'h0001);
		bus(0, ADDR_CTRL, 0);
		chk("ctrl exit", 16'h0005, rdat);
		chk("safety on", 16'h0001, sn);
	endtask : serial_masked
	task automatic thermal;
		// Thermal pulse one short of the filter, then a long one
		hi_for(3);
		bus(0, ADDR_STAT0, 0);
		chk("stat0 short", 16'h0000, rdat);
		hi_for(6);
		bus(0, ADDR_STAT0, 0);
		chk("stat0 therm", 16'h0001, rdat);
		chk("safety off", 16'h0000, sn);
	endtask : thermal
	task automatic fault_events;
		// Ground fault with shared case 2, then engine-off events with actions on
		bus(1, ADDR_CFG0, 16'h0080);
		bus(1, ADDR_CFG1, 16'h0007);
		flt[3] <= 1;
		wait_resp(20);
		chk("arch resp", 16'h0006, {rv, rc});
		flt[3] <= 0;
		bus(0, ADDR_STAT0, 0);
		chk("stat0 arch", 16'h0011, rdat);
		@(posedge clk);
		flt[16:13] <= 4'h7;
		@(posedge clk);
		flt[16:13] <= 4'h0;
		#1;
		chk("low power", 16'h0003, {lpe, lpx});
		bus(0, ADDR_STAT1, 0);
		chk("stat1 eot", 16'h0007, rdat);
	endtask : fault_events
	task automatic pins;
		// Pin 0 forced high, pin 1 held while its raw level falls
		pin <= 8'h02;
		bus(1, ADDR_OVR, 16'h0006);
		pin <= 8'h00;
		repeat (2) @(posedge clk);
		#1;
		chk("pin value", 16'h0003, pv);
	endtask : pins
	task automatic sst_timeout;
		// Second reset, then let the self-test timer run out
		reset_dut();
		wait_resp(300);
		chk("sst resp", 16'h0007, {rv, rc});
		bus(0, ADDR_STAT0, 0);
		chk("stat0 sst", 16'h4000, rdat);
		chk("int sst", 16'h0000, intn);
		bus(1, ADDR_CTRL, 16'h0001);
		bus(0, ADDR_CTRL, 0);
		chk("ctrl late exit", 16'h0005, rdat);
	endtask : sst_timeout
	initial begin
		reset_dut();
		serial_masked();
		thermal();
		fault_events();
		pins();
		sst_timeout();
		finish_test();
	end
endmodule : fst_top_test
